// ---- hw/rt_counter_16bit.sv ----
// 16-bit real-time counter with APB registers, interrupt and events.
// Assumes reference clock pins are slow levels synchronous to pclk.
//
// What this block does
// R1 - A 16-bit counter keeps counting continuously once enabled.
// R2 - Software picks crystal, external, internal or low-power source.
// R3 - With the crystal, software picks 1.024 kHz or full 32.768 kHz.
// R4 - A 10-bit prescaler divides the source before the counter.
// R5 - With no division the counter steps once per source period.
// R6 - A compare match is signalled when the count equals compare.
// R7 - An overflow is signalled when the count equals the period.
// R8 - An overflow clears the counter back to zero.
// R9 - Overflow and match each go to interrupt, event, or both.
// R10 - Sleep does not stop the counter.
// R11 - Matches can wake the system or interrupt it periodically.
// R12 - Count and flags are registered into the bus domain for reads.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module rt_counter_16bit
  import rt_counter_pkg::*;
#(
  parameter int PSC_WIDTH = rt_counter_pkg::PSC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_clk,
  input wire logic ext_clk,
  input wire logic rc32k_clk,
  input wire logic ultra_low_power_oscillator_clk,
  input wire logic sleep_active,
  output logic irq,
  output logic ovf_event,
  output logic cmp_event,
  output logic wake
);

  import rt_counter_pkg::*;

  // ==========================================================
  // Bus state machine
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_e;

  bus_state_e bus_state_reg;
  bus_state_e bus_state_next;

  logic [13:0] ctrl_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] period_reg;
  logic [CNT_W-1:0] compare_reg;
  logic [3:0] route_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [CNT_W-1:0] count_view_reg;
  logic [1:0] status_view_reg;

  logic [3:0] ref_prev_reg;
  logic [4:0] xtal_div_reg;
  logic xtal_slow_reg;

  logic [ADDR_W-1:0] addr;
  logic wr_strobe;
  logic rd_strobe;
  logic addr_ok;
  logic [31:0] rd_data;
  logic [31:0] wmask;

  logic [1:0] src_sel;
  logic full_rate;
  logic run_en;
  logic [PSC_WIDTH-1:0] psc_div;
  logic [3:0] ref_rise;
  logic xtal_pulse;
  logic src_pulse;
  logic tick;
  logic ovf_hit;
  logic cmp_hit;
  logic [1:0] hits;
  logic [1:0] clr_bits;

  assign addr = paddr[ADDR_W-1:0];
  assign src_sel = ctrl_reg[CTRL_SRC_LSB +: 2];
  assign full_rate = ctrl_reg[CTRL_FULL_BIT];
  assign run_en = ctrl_reg[CTRL_EN_BIT];
  assign psc_div = PSC_WIDTH'(ctrl_reg[CTRL_PSC_LSB +: PSC_W]);

  // ==========================================================
  // Byte-lane write mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // ==========================================================
  // Address decode
  always_comb begin
    case (addr)
      OFS_CTRL,
      OFS_COUNT,
      OFS_PERIOD,
      OFS_COMPARE,
      OFS_ROUTE,
      OFS_STATUS,
      OFS_MASK: addr_ok = (paddr[31:ADDR_W] == '0);
      default: addr_ok = 1'b0;
    endcase
  end

  // Writes land at the edge that samples pready high
  always_comb begin
    case (bus_state_reg)
      BUS_IDLE: begin
        bus_state_next = (psel && penable) ? BUS_ANSWER : BUS_IDLE;
      end
      BUS_ANSWER: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  assign wr_strobe = (bus_state_reg == BUS_ANSWER) && psel && penable &&
                     pwrite && addr_ok;
  // Unmapped writes also load zero read data
  assign rd_strobe = (bus_state_reg == BUS_IDLE) && psel && penable &&
                     (!pwrite || !addr_ok);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= (bus_state_next == BUS_ANSWER);
      pslverr <= (bus_state_next == BUS_ANSWER) && !addr_ok;
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    case (addr)
      OFS_CTRL: rd_data[13:0] = ctrl_reg;
      OFS_COUNT: rd_data[CNT_W-1:0] = count_view_reg; // see R12
      OFS_PERIOD: rd_data[CNT_W-1:0] = period_reg;
      OFS_COMPARE: rd_data[CNT_W-1:0] = compare_reg;
      OFS_ROUTE: rd_data[3:0] = route_reg;
      OFS_STATUS: rd_data[1:0] = status_view_reg; // see R12
      OFS_MASK: rd_data[1:0] = mask_reg;
      default: rd_data = 32'h0000_0000;
    endcase
    if (!addr_ok) begin
      rd_data = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_strobe) begin
      prdata <= rd_data;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_strobe && addr == OFS_CTRL) begin
      ctrl_reg <= (ctrl_reg & ~wmask[13:0]) | (pwdata[13:0] & wmask[13:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_reg <= PERIOD_RST;
    end else if (wr_strobe && addr == OFS_PERIOD) begin
      period_reg <= (period_reg & ~wmask[15:0]) |
                    (pwdata[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_reg <= COMPARE_RST;
    end else if (wr_strobe && addr == OFS_COMPARE) begin
      compare_reg <= (compare_reg & ~wmask[15:0]) |
                     (pwdata[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_reg <= ROUTE_RST;
    end else if (wr_strobe && addr == OFS_ROUTE) begin
      route_reg <= (route_reg & ~wmask[3:0]) | (pwdata[3:0] & wmask[3:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= MASK_RST;
    end else if (wr_strobe && addr == OFS_MASK) begin
      mask_reg <= (mask_reg & ~wmask[1:0]) | (pwdata[1:0] & wmask[1:0]);
    end
  end

  // ==========================================================
  // Reference source edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_reg <= 4'h0;
    end else begin
      ref_prev_reg <= {ultra_low_power_oscillator_clk, rc32k_clk,
                       ext_clk, xtal_clk};
    end
  end

  assign ref_rise = {ultra_low_power_oscillator_clk, rc32k_clk,
                     ext_clk, xtal_clk} & ~ref_prev_reg;

  // Crystal divided down to 1.024 kHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_div_reg <= 5'h00;
      xtal_slow_reg <= 1'b0;
    end else begin
      xtal_slow_reg <= 1'b0;
      if (ref_rise[SRC_XTAL]) begin
        if (xtal_div_reg == XTAL_DIV_LAST) begin
          xtal_div_reg <= 5'h00;
          xtal_slow_reg <= 1'b1;
        end else begin
          xtal_div_reg <= xtal_div_reg + 5'h01;
        end
      end
    end
  end

  assign xtal_pulse = full_rate ? ref_rise[SRC_XTAL] : xtal_slow_reg; // see R3

  // Source select
  always_comb begin
    case (src_e'(src_sel))
      SRC_XTAL: src_pulse = xtal_pulse; // see R2
      SRC_EXT: src_pulse = ref_rise[SRC_EXT];
      SRC_RC32K: src_pulse = ref_rise[SRC_RC32K];
      SRC_ULTRA_LOW_POWER: src_pulse = ref_rise[SRC_ULTRA_LOW_POWER];
      default: src_pulse = 1'b0;
    endcase
  end

  // ==========================================================
  // Prescaler
  rt_prescaler #(
    .W(PSC_WIDTH)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clr(!run_en),
    .in_en(src_pulse & run_en),
    .div(psc_div),
    .out_en(tick)
  ); // see R4, see R5

  // ==========================================================
  // Counter
  assign ovf_hit = tick && (count_reg == period_reg); // see R7
  assign cmp_hit = tick && (count_reg == compare_reg); // see R6
  assign hits = {cmp_hit, ovf_hit};

  // Sleep is not an input to the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (wr_strobe && addr == OFS_COUNT) begin
      count_reg <= (count_reg & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
    end else if (ovf_hit) begin
      count_reg <= '0; // see R8
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001; // see R1, see R10
    end
  end

  // ==========================================================
  // Sticky status, write one to clear, set wins
  assign clr_bits = (wr_strobe && addr == OFS_STATUS) ?
                    (pwdata[1:0] & wmask[1:0]) : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 2'h0;
    end else begin
      status_reg <= (status_reg & ~clr_bits) | hits;
    end
  end

  // Registered views for the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_view_reg <= '0;
      status_view_reg <= 2'h0;
    end else begin
      count_view_reg <= count_reg; // see R12
      status_view_reg <= (status_reg & ~clr_bits) | hits; // see R12
    end
  end

  // ==========================================================
  // Interrupt, events and wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_reg & ~clr_bits) | hits) &
               mask_reg); // see R9, see R11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_event <= 1'b0;
      cmp_event <= 1'b0;
    end else begin
      ovf_event <= ovf_hit & route_reg[ROUTE_OVF_EVT]; // see R9
      cmp_event <= cmp_hit & route_reg[ROUTE_CMP_EVT]; // see R9
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake <= 1'b0;
    end else begin
      wake <= sleep_active &
              ((ovf_hit & route_reg[ROUTE_OVF_WAKE]) |
               (cmp_hit & route_reg[ROUTE_CMP_WAKE])); // see R11
    end
  end

endmodule : rt_counter_16bit

// ---- hw/rt_counter_pkg.sv ----
// Package for the 16-bit real-time counter: register map, fields, resets.
// Assumes a 32-bit APB slave port and a single 50 MHz pclk domain.
package rt_counter_pkg;

  // ==========================================================
  // Widths
  localparam int CNT_W = 16;
  localparam int PSC_W = 10;
  localparam int ADDR_W = 8;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ROUTE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;

  // ==========================================================
  // Control fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_FULL_BIT = 2;
  localparam int CTRL_EN_BIT = 3;
  localparam int CTRL_PSC_LSB = 4;

  // Route fields: event outputs and wake enables
  localparam int ROUTE_OVF_EVT = 0;
  localparam int ROUTE_CMP_EVT = 1;
  localparam int ROUTE_OVF_WAKE = 2;
  localparam int ROUTE_CMP_WAKE = 3;

  // Status and mask fields
  localparam int ST_OVF = 0;
  localparam int ST_CMP = 1;

  // ==========================================================
  // Reset values
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
  localparam logic [CNT_W-1:0] COMPARE_RST = 16'h0000;
  localparam logic [3:0] ROUTE_RST = 4'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // ==========================================================
  // Crystal divider giving 1.024 kHz from 32.768 kHz
  localparam int XTAL_FULL_HZ = 32768;
  localparam int XTAL_SLOW_HZ = 1024;
  localparam int XTAL_DIV = XTAL_FULL_HZ / XTAL_SLOW_HZ;
  localparam logic [4:0] XTAL_DIV_LAST = 5'(XTAL_DIV - 1);

  // Reference source codes
  typedef enum logic [1:0] {
    SRC_XTAL = 2'h0,
    SRC_EXT = 2'h1,
    SRC_RC32K = 2'h2,
    SRC_ULTRA_LOW_POWER = 2'h3
  } src_e;

endpackage : rt_counter_pkg

// ---- hw/rt_prescaler.sv ----
// Programmable prescaler: one output pulse per (div + 1) input pulses.
// Assumes in_en is a one-cycle pulse in the pclk domain.
`timescale 1ns/1ns
module rt_prescaler #(
  parameter int W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic in_en,
  input wire logic [W-1:0] div,
  output logic out_en
);

  logic [W-1:0] cnt_reg;

  // ==========================================================
  // Divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (clr) begin
      cnt_reg <= '0;
    end else if (in_en) begin
      if (cnt_reg >= div) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // Zero division passes every pulse through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_en <= 1'b0;
    end else begin
      out_en <= in_en & ~clr & (cnt_reg >= div);
    end
  end

endmodule : rt_prescaler

// ---- bench/rt_counter_props.sv ----
// Checker for the real-time counter: bus answers and output pulses.
// Assumes it is bound onto rt_counter_16bit, one pclk domain.
`timescale 1ns/1ns
module rt_counter_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_active,
  input wire logic irq,
  input wire logic ovf_event,
  input wire logic cmp_event,
  input wire logic wake
);
  import rt_counter_pkg::*;
  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_one_wait_state: assert property (
    psel && penable && !pready && !$past(penable) |=> pready)
    else $error("pready not one cycle after access");
  a_ready_cause: assert property (
    pready |-> $past(psel && penable))
    else $error("pready without a request");
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("pready longer than one cycle");
  a_error_answer: assert property (
    pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  a_wake_in_sleep: assert property (
    wake |-> $past(sleep_active))
    else $error("wake outside sleep");
  a_ovf_pulse: assert property (
    ovf_event |=> !ovf_event)
    else $error("overflow event too long");
  a_cmp_pulse: assert property (
    cmp_event |=> !cmp_event)
    else $error("compare event too long");
  a_irq_fall_write: assert property (
    $fell(irq) |-> $past(penable && pwrite) || $past(penable && pwrite, 2))
    else $error("irq fell without a write");
  // ==========================================================
  // Covers
  c_ovf: cover property (ovf_event);
  c_wake: cover property (wake);
  c_irq_clear: cover property ($fell(irq));
endmodule : rt_counter_props

bind rt_counter_16bit rt_counter_props chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .sleep_active, .irq, .ovf_event, .cmp_event, .wake
);

// ---- bench/tb.sv ----
// Self-checking bench for the real-time counter over APB.
// Assumes reference levels are driven here, synchronous to pclk.
`timescale 1ns/1ns
module tb;
  import rt_counter_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0] ref_lv = '0;
  logic sleep_active = 0, pready, pslverr, irq, ovf_event, cmp_event, wake;
  logic err;
  int errors = 0, checks = 0, cyc = 0, n_ovf = 0, n_cmp = 0, n_wake = 0;
  int b_ovf, b_cmp, b_wake;
  logic [7:0] ofs [7] = '{OFS_CTRL, OFS_COUNT, OFS_PERIOD, OFS_COMPARE,
    OFS_ROUTE, OFS_STATUS, OFS_MASK};
  logic [31:0] rst [7] = '{32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0,
    32'h0};
  logic [13:0] cfg [6] = '{14'h0008, 14'h000c, 14'h0029, 14'h002a,
    14'h001b, 14'h3ff9};
  int n_edge [6] = '{64, 5, 6, 6, 4, 1024};
  logic [31:0] expc [6] = '{32'h2, 32'h5, 32'h2, 32'h2, 32'h2, 32'h1};

  always #10 pclk = ~pclk;

  rt_counter_16bit dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_clk(ref_lv[0]), .ext_clk(ref_lv[1]), .rc32k_clk(ref_lv[2]),
    .ultra_low_power_oscillator_clk(ref_lv[3]),
    .sleep_active(sleep_active), .irq(irq), .ovf_event(ovf_event),
    .cmp_event(cmp_event), .wake(wake)
  );

  // ==========================================================
  // Tasks
  task close_out();
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc

  task edges(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge pclk);
      ref_lv <= m;
      repeat (2) @(posedge pclk);
      ref_lv <= 4'h0;
      @(posedge pclk);
    end
    repeat (5) @(posedge pclk);
  endtask : edges

  // ==========================================================
  // Monitors and timeout
  always @(posedge pclk) begin
    cyc++;
    if (ovf_event === 1'b1) n_ovf++;
    if (cmp_event === 1'b1) n_cmp++;
    if (wake === 1'b1) n_wake++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[i]) rc(ofs[i], rst[i]);
    rc(8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFS_PERIOD, 32'h3);
    apb(1'b1, OFS_COMPARE, 32'h2);
    apb(1'b1, OFS_ROUTE, 32'h3);
    apb(1'b1, OFS_MASK, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h9);
    b_ovf = n_ovf;
    b_cmp = n_cmp;
    edges(4'h2, 4);
    chk(32'(n_ovf - b_ovf), 32'h1);
    chk(32'(n_cmp - b_cmp), 32'h1);
    rc(OFS_COUNT, 32'h0);
    rc(OFS_STATUS, 32'h3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rc(OFS_STATUS, 32'h2);
    apb(1'b1, OFS_PERIOD, 32'hffff);
    foreach (cfg[i]) begin
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_COUNT, 32'h0);
      apb(1'b1, OFS_CTRL, {18'h0, cfg[i]});
      rc(OFS_CTRL, {18'h0, cfg[i]});
      edges(4'h1 << cfg[i][1:0], n_edge[i]);
      edges(~(4'h1 << cfg[i][1:0]), 3);
      rc(OFS_COUNT, expc[i]);
    end
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_PERIOD, 32'h1);
    apb(1'b1, OFS_COMPARE, 32'h0);
    apb(1'b1, OFS_ROUTE, 32'hc);
    apb(1'b1, OFS_COUNT, 32'h0);
    sleep_active <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h9);
    b_ovf = n_ovf;
    b_cmp = n_cmp;
    b_wake = n_wake;
    edges(4'h2, 3);
    chk(32'(n_wake - b_wake), 32'h3);
    chk(32'(n_ovf + n_cmp - b_ovf - b_cmp), 32'h0);
    rc(OFS_COUNT, 32'h1);
    sleep_active <= 1'b0;
    edges(4'h2, 2);
    chk(32'(n_wake - b_wake), 32'h3);
    rc(OFS_COUNT, 32'h1);
    close_out();
  end
endmodule : tb
